// ---- core/rsc_command_port.sv ----
// Serial slave command port with interrupt routing and pin delegation
`timescale 1ns/1ps
// Overview of operation
// - The block is only a serial slave: clock, select and data in come from the host.
// - A falling select starts a new command frame; the bit and byte counters are held reset while select is high.
// - While select is high the serial output enable stays low.
// - Opcode 08 loads the enable mask and the three pin route masks, 16 bits each.
// - Opcode 12 shifts the current triggered flags out on the serial output.
// - Opcode 02 clears the flags whose bits the host sends.
// - Opcode 9d with enable set makes pin two drive the transmit path switch.
// - Opcode 97 takes a supply level and 24-bit timeout and drives pin three as supply.
module rsc_command_port (
    input  wire logic        ref_clk_i,        // System clock
    input  wire logic        reset_i,          // Synchronous reset, active high
    input  wire logic        radio_reset_n_i,  // Pin reset, active low
    input  wire logic        sck_i,            // Serial clock from host
    input  wire logic        nss_n_i,          // Slave select, active low
    input  wire logic        mosi_i,           // Serial data in
    output logic             miso_o,           // Serial data out
    output logic             miso_oe_o,        // Serial out enable
    input  wire logic [15:0] irq_event_i,      // Radio event pulses
    input  wire logic        tx_active_i,      // Radio transmitting
    input  wire logic        tx_path_select_i, // Tx switch input sense
    input  wire logic        rx_path_select_i, // Rx switch input sense
    output logic             multi_pin_one_o,  // Interrupt pin one
    output logic             multi_pin_two_o,  // Interrupt pin two or rf switch
    output logic             multi_pin_three_o,// Interrupt pin three or osc supply
    output logic [7:0]       osc_level_o,      // Selected oscillator supply level
    output logic [23:0]      osc_timeout_o,    // Oscillator timeout
    output logic             tx_path_o,        // Synced tx path select
    output logic             rx_path_o,        // Synced rx path select
    output logic             busy_o            // Busy indication
);
    // ----------------------------------------
    // Reset combination
    // ----------------------------------------
    logic [1:0] nrst_sync_r;
    logic [1:0] path_sync1_r, path_sync2_r;
    logic       rst;
    always_ff @(posedge ref_clk_i) begin
        nrst_sync_r  <= {nrst_sync_r[0], radio_reset_n_i};
        path_sync1_r <= {tx_path_select_i, rx_path_select_i};
        path_sync2_r <= path_sync1_r;
    end
    assign rst = reset_i || !nrst_sync_r[1];
    assign tx_path_o = path_sync2_r[1];
    assign rx_path_o = path_sync2_r[0];

    // ----------------------------------------
    // Serial clock domain
    // ----------------------------------------
    logic [2:0]  bit_cnt_r;
    logic [6:0]  shift_r;
    logic [7:0]  opcode_r;
    logic [3:0]  byte_cnt_r;
    logic        have_op_r;
    logic [7:0]  byte_buf_r;
    logic [3:0]  byte_idx_r;
    // Toggles start low so the crossing never carries an unknown level
    logic        byte_tgl_r  = 1'b0;
    logic        frame_tgl_r = 1'b0;
    logic [23:0] out_sr_r;
    logic [15:0] flags_snap_x;
    logic [7:0]  rx_byte;
    assign rx_byte = {shift_r, mosi_i};

    // Byte assembly on rising sck, frame starts with select low
    always_ff @(posedge sck_i or posedge nss_n_i) begin
        if (nss_n_i) begin
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 4'h0;
            have_op_r  <= 1'b0;
            shift_r    <= 7'h00;
        end else begin
            shift_r   <= rx_byte[6:0];
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
                if (!have_op_r) begin
                    opcode_r  <= rx_byte;
                    have_op_r <= 1'b1;
                end else begin
                    byte_buf_r <= rx_byte;
                    byte_idx_r <= byte_cnt_r;
                    byte_cnt_r <= byte_cnt_r + 4'h1;
                    byte_tgl_r <= ~byte_tgl_r;
                end
            end
        end
    end

    // Frame end toggle on select rise
    always_ff @(posedge nss_n_i) begin
        frame_tgl_r <= ~frame_tgl_r;
    end

    // Status out shifts on falling sck: status byte then flags
    always_ff @(negedge sck_i or posedge nss_n_i) begin
        if (nss_n_i) begin
            out_sr_r <= 24'h000000;
        end else if (bit_cnt_r == 3'h0 && !have_op_r && byte_cnt_r == 4'h0) begin
            out_sr_r <= {out_sr_r[22:0], 1'b0};
        end else if (bit_cnt_r == 3'h0 && have_op_r && byte_cnt_r == 4'h0
                     && opcode_r == rsc_pkg::OP_READ_IRQ) begin
            out_sr_r <= {8'h00, flags_snap_x};
        end else begin
            out_sr_r <= {out_sr_r[22:0], 1'b0};
        end
    end
    assign miso_o    = out_sr_r[23];
    assign miso_oe_o = !nss_n_i;

    // ----------------------------------------
    // Crossing into the system clock
    // ----------------------------------------
    logic [2:0] byte_sync_r, frame_sync_r;
    logic       byte_evt, frame_evt;
    always_ff @(posedge ref_clk_i) begin
        byte_sync_r  <= {byte_sync_r[1:0], byte_tgl_r};
        frame_sync_r <= {frame_sync_r[1:0], frame_tgl_r};
    end
    assign byte_evt  = byte_sync_r[2] ^ byte_sync_r[1];
    assign frame_evt = frame_sync_r[2] ^ frame_sync_r[1];

    // ----------------------------------------
    // Command decode and configuration
    // ----------------------------------------
    rsc_pkg::rsc_cfg_s cfg_r;
    logic [15:0]       flags_r;
    logic [15:0]       clr_acc_r;
    logic [15:0]       clr_now;
    logic [7:0]        stable_op;
    logic [7:0]        stable_byte;
    logic [3:0]        stable_idx;
    // Opcode and byte are stable for a full byte time when the toggle lands
    assign stable_op   = opcode_r;
    assign stable_byte = byte_buf_r;
    assign stable_idx  = byte_idx_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            cfg_r.interrupt_enable_mask   <= rsc_pkg::MASK_RST;
            cfg_r.pin_one_route_mask      <= rsc_pkg::MASK_RST;
            cfg_r.pin_two_route_mask      <= rsc_pkg::MASK_RST;
            cfg_r.pin_three_route_mask    <= rsc_pkg::MASK_RST;
            cfg_r.rf_switch_on            <= 1'b0;
            cfg_r.osc_supply_on           <= 1'b0;
            cfg_r.oscillator_supply_level <= rsc_pkg::LEVEL_RST;
            cfg_r.osc_timeout             <= rsc_pkg::TMO_RST;
        end else if (byte_evt) begin
            case (stable_op)
                rsc_pkg::OP_ROUTE_IRQ: begin
                    case (stable_idx)
                        4'h0: cfg_r.interrupt_enable_mask[15:8] <= stable_byte;
                        4'h1: cfg_r.interrupt_enable_mask[7:0]  <= stable_byte;
                        4'h2: cfg_r.pin_one_route_mask[15:8]    <= stable_byte;
                        4'h3: cfg_r.pin_one_route_mask[7:0]     <= stable_byte;
                        4'h4: cfg_r.pin_two_route_mask[15:8]    <= stable_byte;
                        4'h5: cfg_r.pin_two_route_mask[7:0]     <= stable_byte;
                        4'h6: cfg_r.pin_three_route_mask[15:8]  <= stable_byte;
                        4'h7: cfg_r.pin_three_route_mask[7:0]   <= stable_byte;
                        default: ;
                    endcase
                end
                rsc_pkg::OP_RF_SWITCH: begin
                    if (stable_idx == 4'h0) begin
                        cfg_r.rf_switch_on <= stable_byte[0];
                    end
                end
                rsc_pkg::OP_OSC_SUPPLY: begin
                    case (stable_idx)
                        4'h0: cfg_r.oscillator_supply_level <= stable_byte;
                        4'h1: cfg_r.osc_timeout[23:16]      <= stable_byte;
                        4'h2: cfg_r.osc_timeout[15:8]       <= stable_byte;
                        4'h3: begin
                            cfg_r.osc_timeout[7:0] <= stable_byte;
                            cfg_r.osc_supply_on    <= 1'b1;
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // Clear mask gathered from opcode 02 parameter bytes
    always_comb begin
        clr_now = 16'h0000;
        if (byte_evt && stable_op == rsc_pkg::OP_CLEAR_IRQ) begin
            if (stable_idx == 4'h0) begin
                clr_now = {stable_byte, 8'h00};
            end else if (stable_idx == 4'h1) begin
                clr_now = {clr_acc_r[15:8], stable_byte};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            clr_acc_r <= 16'h0000;
        end else if (byte_evt && stable_idx == 4'h0) begin
            clr_acc_r <= {stable_byte, 8'h00};
        end
    end

    // Sticky flags, a new event wins over a clear
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            flags_r <= 16'h0000;
        end else if (stable_idx == 4'h1 && clr_now != 16'h0000) begin
            flags_r <= (flags_r & ~clr_now)
                       | (irq_event_i & cfg_r.interrupt_enable_mask);
        end else begin
            flags_r <= flags_r | (irq_event_i & cfg_r.interrupt_enable_mask);
        end
    end
    // Flags passed straight through to the status shifter, not held while a frame is open
    assign flags_snap_x = flags_r;

    // ----------------------------------------
    // Busy and pins
    // ----------------------------------------
    logic [3:0] busy_cnt_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            busy_cnt_r <= 4'(rsc_pkg::BUSY_CYC);
        end else if (frame_evt) begin
            busy_cnt_r <= 4'(rsc_pkg::BUSY_CYC);
        end else if (busy_cnt_r != 4'h0) begin
            busy_cnt_r <= busy_cnt_r - 4'h1;
        end
    end
    assign busy_o = busy_cnt_r != 4'h0;

    // Pin outputs from flops
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            multi_pin_one_o   <= 1'b0;
            multi_pin_two_o   <= 1'b0;
            multi_pin_three_o <= 1'b0;
        end else begin
            multi_pin_one_o <= |(flags_r & cfg_r.pin_one_route_mask);
            multi_pin_two_o <= cfg_r.rf_switch_on ? tx_active_i
                               : |(flags_r & cfg_r.pin_two_route_mask);
            multi_pin_three_o <= cfg_r.osc_supply_on ? 1'b1
                                 : |(flags_r & cfg_r.pin_three_route_mask);
        end
    end
    assign osc_level_o   = cfg_r.oscillator_supply_level;
    assign osc_timeout_o = cfg_r.osc_timeout;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_miso_off;
        @(posedge ref_clk_i) disable iff (rst) nss_n_i |-> !miso_oe_o;
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("miso enabled while deselected");

    property p_pin_one;
        @(posedge ref_clk_i) disable iff (rst)
            |(flags_r & cfg_r.pin_one_route_mask) |=> multi_pin_one_o;
    endproperty
    a_pin_one: assert property (p_pin_one) else $error("pin one not raised");

    property p_flag_set;
        @(posedge ref_clk_i) disable iff (rst)
            |(irq_event_i & cfg_r.interrupt_enable_mask) |=> flags_r != 16'h0000;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost");

    property p_busy_frame;
        @(posedge ref_clk_i) disable iff (rst) frame_evt |=> busy_o [*3];
    endproperty
    a_busy_frame: assert property (p_busy_frame) else $error("busy not held");

    property p_rf_pin;
        @(posedge ref_clk_i) disable iff (rst)
            cfg_r.rf_switch_on && $stable(cfg_r.rf_switch_on) |=> multi_pin_two_o == $past(tx_active_i);
    endproperty
    a_rf_pin: assert property (p_rf_pin) else $error("pin two not following tx");

    property p_osc_pin;
        @(posedge ref_clk_i) disable iff (rst) cfg_r.osc_supply_on |=> multi_pin_three_o;
    endproperty
    a_osc_pin: assert property (p_osc_pin) else $error("pin three supply off");

    property p_reset_pin;
        @(posedge ref_clk_i) !nrst_sync_r[1] |=> flags_r == 16'h0000 && !busy_cnt_r[3];
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("radio reset ignored");

    property p_busy_fall;
        @(posedge ref_clk_i) disable iff (rst) $fell(busy_o) |-> !frame_evt;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell on frame end");
endmodule // rsc_command_port

// ---- core/rsc_pkg.sv ----
// Constants and carrier types for the radio command port
package rsc_pkg;
    // Opcodes
    localparam logic [7:0] OP_ROUTE_IRQ  = 8'h08;
    localparam logic [7:0] OP_READ_IRQ   = 8'h12;
    localparam logic [7:0] OP_CLEAR_IRQ  = 8'h02;
    localparam logic [7:0] OP_RF_SWITCH  = 8'h9d;
    localparam logic [7:0] OP_OSC_SUPPLY = 8'h97;
    // Parameter byte counts per opcode
    localparam logic [3:0] LEN_ROUTE_IRQ  = 4'h8;
    localparam logic [3:0] LEN_READ_IRQ   = 4'h3;
    localparam logic [3:0] LEN_CLEAR_IRQ  = 4'h2;
    localparam logic [3:0] LEN_RF_SWITCH  = 4'h1;
    localparam logic [3:0] LEN_OSC_SUPPLY = 4'h4;
    // Reset values
    localparam logic [15:0] MASK_RST  = 16'h0000;
    localparam logic [7:0]  LEVEL_RST = 8'h00;
    localparam logic [23:0] TMO_RST   = 24'h000000;
    // Busy hold after a frame, in ref clock cycles
    localparam int BUSY_NS       = 200;
    localparam int REF_PERIOD_NS = 50;
    localparam int BUSY_CYC      = (BUSY_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    // Configuration carried from the command decoder to the pins
    typedef struct packed {
        logic [15:0] interrupt_enable_mask;
        logic [15:0] pin_one_route_mask;
        logic [15:0] pin_two_route_mask;
        logic [15:0] pin_three_route_mask;
        logic        rf_switch_on;
        logic        osc_supply_on;
        logic [7:0]  oscillator_supply_level;
        logic [23:0] osc_timeout;
    } rsc_cfg_s;
endpackage

// ---- test/rsc_command_port_tb.sv ----
// Self-checking bench for the radio command port
`timescale 1ns/1ps
`define RSC_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module rsc_command_port_tb;
    logic ref_clk_i = 0, reset_i = 1, radio_reset_n_i = 1, tx_active_i = 0;
    logic tx_path_select_i = 0, rx_path_select_i = 0, miso_hold = 0, ok;
    logic [15:0] irq_event_i = '0;
    logic        sck, nss_n, mosi, miso_o, miso_oe_o, busy_o, tx_path_o, rx_path_o;
    logic        multi_pin_one_o, multi_pin_two_o, multi_pin_three_o;
    logic [7:0]  osc_level_o;
    logic [23:0] osc_timeout_o;
    logic [71:0] rx_q;
    wire         miso_w;
    int          num_errors = 0, n_compared = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    // Released serial output shows the inverse of its last level
    always @(miso_o) if (miso_oe_o) miso_hold = miso_o;
    assign miso_w = miso_oe_o ? miso_o : ~miso_hold;

    rsc_command_port uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .radio_reset_n_i(radio_reset_n_i), .sck_i(sck), .nss_n_i(nss_n), .mosi_i(mosi),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o), .irq_event_i(irq_event_i),
        .tx_active_i(tx_active_i), .tx_path_select_i(tx_path_select_i),
        .rx_path_select_i(rx_path_select_i), .multi_pin_one_o(multi_pin_one_o),
        .multi_pin_two_o(multi_pin_two_o), .multi_pin_three_o(multi_pin_three_o),
        .osc_level_o(osc_level_o), .osc_timeout_o(osc_timeout_o),
        .tx_path_o(tx_path_o), .rx_path_o(rx_path_o), .busy_o(busy_o));

    rsc_host_model host (.sck_o(sck), .nss_n_o(nss_n), .mosi_o(mosi), .miso_i(miso_w),
        .busy_i(busy_o));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic settle;
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask

    // One command frame, then the select released check
    task automatic cmd(input int nb, input logic [71:0] tx);
        host.frame(nb, tx, rx_q, ok);
        if (!ok) begin
            num_errors++;
            $display("[FAIL] %0t busy never dropped", $time);
            print_verdict;
        end
        `RSC_CHK(busy_o, 1'b1)
        settle;
        `RSC_CHK(miso_oe_o, 1'b0)
        `RSC_CHK(busy_o, 1'b0)
    endtask

    // One-cycle event pulse in the system domain
    task automatic pulse(input logic [15:0] m);
        @(posedge ref_clk_i) irq_event_i <= m;
        @(posedge ref_clk_i) irq_event_i <= '0;
        settle;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        settle;
        `RSC_CHK({multi_pin_one_o, multi_pin_two_o, multi_pin_three_o}, 3'b000)
        // Enable bits 0 and 1, bit 2 stays masked
        cmd(9, {rsc_pkg::OP_ROUTE_IRQ, 16'h0003, 16'h0001, 16'h0002, 16'h0002});
        pulse(16'h0007);
        `RSC_CHK({multi_pin_one_o, multi_pin_two_o, multi_pin_three_o}, 3'b111)
        // Read answers a zero status byte, then flags high and low
        cmd(4, {rsc_pkg::OP_READ_IRQ, 24'h000000});
        `RSC_CHK(rx_q[23:16], 8'h00)
        `RSC_CHK(rx_q[15:0], 16'h0003)
        cmd(3, {rsc_pkg::OP_CLEAR_IRQ, 16'h0001});
        `RSC_CHK({multi_pin_one_o, multi_pin_two_o, multi_pin_three_o}, 3'b011)
        cmd(4, {rsc_pkg::OP_READ_IRQ, 24'h000000});
        `RSC_CHK(rx_q[15:0], 16'h0002)
        // Unknown opcode leaves flags alone
        cmd(3, {8'h55, 16'hffff});
        `RSC_CHK({multi_pin_one_o, multi_pin_two_o, multi_pin_three_o}, 3'b011)
        cmd(3, {rsc_pkg::OP_CLEAR_IRQ, 16'hffff});
        `RSC_CHK({multi_pin_one_o, multi_pin_two_o, multi_pin_three_o}, 3'b000)
        // Pin two follows transmit activity once delegated
        cmd(2, {rsc_pkg::OP_RF_SWITCH, 8'h01});
        @(posedge ref_clk_i) tx_active_i <= 1'b1;
        settle;
        `RSC_CHK(multi_pin_two_o, 1'b1)
        @(posedge ref_clk_i) tx_active_i <= 1'b0;
        settle;
        `RSC_CHK(multi_pin_two_o, 1'b0)
        // Oscillator supply level, timeout and pin three
        cmd(5, {rsc_pkg::OP_OSC_SUPPLY, 8'h02, 24'h0a0b0c});
        `RSC_CHK(osc_level_o, 8'h02)
        `RSC_CHK(osc_timeout_o, 24'h0a0b0c)
        `RSC_CHK(multi_pin_three_o, 1'b1)
        // Every path select combination reaches the outputs
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk_i) {tx_path_select_i, rx_path_select_i} <= 2'(k);
            settle;
            `RSC_CHK({tx_path_o, rx_path_o}, 2'(k))
        end
        // Pin reset clears the configuration
        @(posedge ref_clk_i) radio_reset_n_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        radio_reset_n_i <= 1'b1;
        settle;
        `RSC_CHK(osc_level_o, rsc_pkg::LEVEL_RST)
        `RSC_CHK({multi_pin_two_o, multi_pin_three_o}, 2'b00)
        cmd(4, {rsc_pkg::OP_READ_IRQ, 24'h000000});
        `RSC_CHK(rx_q[15:0], 16'h0000)
        print_verdict;
    end

    // Overall hang guard
    initial begin
        #2000000;
        num_errors++;
        $display("[FAIL] %0t run timed out", $time);
        print_verdict;
    end
endmodule // rsc_command_port_tb

// ---- test/rsc_host_model.sv ----
// Host side serial master model for the radio command port
`timescale 1ns/1ps
module rsc_host_model (
    output logic      sck_o,   // Serial clock, still outside bytes
    output logic      nss_n_o, // Select, active low
    output logic      mosi_o,  // Serial data to device
    input  wire logic miso_i,  // Resolved serial data from device
    input  wire logic busy_i   // Busy from device
);
    // Idle levels before any frame
    initial begin
        sck_o   = 1'b0;
        nss_n_o = 1'b1;
        mosi_o  = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame transfer, mode 0, MSB first
    // ------------------------------------------------------------
    task automatic frame(input int nb, input logic [71:0] tx, output logic [71:0] rx,
                         output logic ok);
        int t;
        rx = '0;
        t  = 0;
        // Wait for the device to go idle first
        while (busy_i !== 1'b0 && t < 400) begin
            #50;
            t++;
        end
        ok = (t < 400);
        nss_n_o = 1'b0;
        #40;
        for (int i = nb * 8 - 1; i >= 0; i--) begin
            mosi_o = tx[i];
            #3;
            rx     = {rx[70:0], miso_i};
            sck_o  = 1'b1;
            #3;
            sck_o  = 1'b0;
            // Byte gap lets each byte cross into the system domain
            if (i % 8 == 0) #300;
        end
        #40;
        nss_n_o = 1'b1;
        mosi_o  = ~mosi_o; // No stale data once the frame ends
        #200;
    endtask
endmodule // rsc_host_model
